// ===== design/kscan_map.svh
// register offsets, field positions, reset values and timing counts of the key scanner
`ifndef KSCAN_MAP_SVH
`define KSCAN_MAP_SVH
`define KS_OFF_CTRL   12'h000
`define KS_OFF_STAT   12'h004
`define KS_OFF_CODE   12'h008
`define KS_CTRL_EN    0
`define KS_ROWS_LSB   8
`define KS_COLS_LSB   16
`define KS_CTRL_MASK  32'h001f_0f01
`define KS_CTRL_RST   32'h0014_0800
`define KS_ST_GHOST   0
`define KS_ST_OVF     1
`define KS_MAX_ROWS   8
`define KS_MAX_COLS   20
`define KS_BUF_DEPTH  16
`define KS_SYS_HZ     20000000
`define KS_SCAN_HZ    128000
`define KS_TICK_CYC   (`KS_SYS_HZ / `KS_SCAN_HZ)
`define KS_DEB_US     5
`define KS_DEB_CYC    ((`KS_DEB_US * `KS_SYS_HZ) / 1000000)
`endif

// ===== design/kscan_pkg.sv
// types shared by the key matrix scanner
package kscan_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SCAN = 3'h2,
    ST_END  = 3'h4
  } scan_state_e;
endpackage

// ===== design/key_matrix_scanner.sv
// key matrix scanner with apb registers, debounce, ghost check and key code buffer
// Behaviour
// - clock request falls one edge after the scanner is disabled and stays low while it is disabled
// - enabled scanner drops its request when idle, raises it on key press
// - scans up to 160 switches, eight rows by twenty columns, in sequence
// - scanned column count programmable from one to twenty
// - scanned row count programmable from one to eight
// - key codes go into a sixteen byte hardware buffer
// - one position per 128 kHz step, full matrix in about 1.2 ms
// - any number of keys reported; suspected ghost keys are locked out
// - buffered codes stay until read by host; new codes are dropped while the buffer is full
// - row inputs are synchronised and debounced before use
// - machine resets into idle, idle drives all columns high
// - row transition in idle requests clock and enters scan
// - idle clears row-hit register and key index counter
// - row counter wraps at row count, then column counter steps
// - both counters terminal moves machine to scan end
// - key index counts every position and is the stored key code
// - column with two or more hits ors row inputs into row-hit
// - hit on a row already in row-hit sets the ghost status bit
// - scan end rescans if keys found, else idle with request low
`timescale 1ns/1ps
`default_nettype none
`include "kscan_map.svh"
module key_matrix_scanner (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // key matrix
  input  wire logic [7:0]  ROW_I,
  output logic      [19:0] COL_O,
  // shared low-power clock
  input  wire logic        LPCLK_ON_I,
  output logic             LPCLK_REQ_O
);
  kscan_pkg::scan_state_e state_r, state_nxt;
  logic [31:0]  ctrl_r, prdata_r, rdata;
  logic [3:0]   nrows;
  logic [4:0]   ncols, col_cnt_r, buf_cnt_r;
  logic [7:0]   row_mask, s1_r, s2_r, s3_r, row_db_r, row_db_d_r;
  logic [7:0]   tick_cnt_r, row_hit_r, key_idx_r;
  logic [2:0]   row_cnt_r;
  logic [1:0]   col_hits_r;
  logic [159:0] down_r;
  logic [19:0]  col_r;
  logic [7:0]   mem [0:`KS_BUF_DEPTH-1];
  logic [3:0]   wr_ptr_r, rd_ptr_r;
  logic         found_r, ghost_r, ovf_r, req_r, pready_r, pslverr_r;
  logic         enable, tick, hit, last_row, last_col, multi, ghost_now, step;
  logic         press, full, push_ok, pop, acc, done, err, wr_ctrl, wr_stat;

  assign enable = ctrl_r[`KS_CTRL_EN];

  // bad counts are clamped so a stray write cannot run the counters off the matrix
  always_comb begin
    nrows = ctrl_r[`KS_ROWS_LSB +: 4];
    ncols = ctrl_r[`KS_COLS_LSB +: 5];
    if (nrows == 4'h0) begin
      nrows = 4'h1;
    end else if (nrows > 4'(`KS_MAX_ROWS)) begin
      nrows = 4'(`KS_MAX_ROWS);
    end
    if (ncols == 5'h00) begin
      ncols = 5'h01;
    end else if (ncols > 5'(`KS_MAX_COLS)) begin
      ncols = 5'(`KS_MAX_COLS);
    end
  end

  assign row_mask = 8'hff >> (4'h8 - nrows);

  // three-stage sync, then per-row stability filter
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      s1_r       <= 8'h00;
      s2_r       <= 8'h00;
      s3_r       <= 8'h00;
      row_db_d_r <= 8'h00;
    end else begin
      s1_r       <= ROW_I;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      row_db_d_r <= row_db_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `KS_MAX_ROWS; g++) begin : g_deb
      logic [6:0] cnt_r;
      always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
          cnt_r       <= 7'h00;
          row_db_r[g] <= 1'b0;
        end else if (s2_r[g] != s3_r[g] || s3_r[g] == row_db_r[g]) begin
          cnt_r <= 7'h00;
        end else if (cnt_r == 7'(`KS_DEB_CYC - 1)) begin
          cnt_r       <= 7'h00;
          row_db_r[g] <= s3_r[g];
        end else begin
          cnt_r <= cnt_r + 7'h01;
        end
      end
    end
  endgenerate

  // scan step rate; a step also leaves the column settle time before sampling
  assign tick = (tick_cnt_r == 8'(`KS_TICK_CYC - 1));

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || state_r == kscan_pkg::ST_IDLE || tick) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end

  assign hit       = row_db_r[row_cnt_r];
  assign last_row  = (row_cnt_r == 3'(nrows - 4'h1));
  assign last_col  = (col_cnt_r == (ncols - 5'h01));
  assign multi     = (col_hits_r == 2'h2) || (col_hits_r == 2'h1 && hit);
  assign ghost_now = hit && row_hit_r[row_cnt_r];
  assign step      = (state_r == kscan_pkg::ST_SCAN) && tick;
  assign press     = step && hit && !ghost_now && !down_r[key_idx_r];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      kscan_pkg::ST_IDLE: begin
        if (row_db_r != row_db_d_r) begin
          state_nxt = kscan_pkg::ST_SCAN;
        end
      end
      kscan_pkg::ST_SCAN: begin
        if (tick && last_row && last_col) begin
          state_nxt = kscan_pkg::ST_END;
        end
      end
      kscan_pkg::ST_END: begin
        state_nxt = found_r ? kscan_pkg::ST_SCAN : kscan_pkg::ST_IDLE;
      end
    endcase
    if (!enable) begin
      state_nxt = kscan_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state_r <= kscan_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request follows the next state, so it is never late for the first step
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      req_r <= 1'b0;
    end else begin
      req_r <= enable && state_nxt != kscan_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || state_r == kscan_pkg::ST_IDLE) begin
      col_r <= 20'hfffff;
    end else begin
      col_r <= 20'h00001 << col_cnt_r;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || state_r != kscan_pkg::ST_SCAN) begin
      row_cnt_r  <= 3'h0;
      col_cnt_r  <= 5'h00;
      col_hits_r <= 2'h0;
    end else if (tick) begin
      if (last_row) begin
        row_cnt_r  <= 3'h0;
        col_hits_r <= 2'h0;
        if (!last_col) begin
          col_cnt_r <= col_cnt_r + 5'h01;
        end
      end else begin
        row_cnt_r <= row_cnt_r + 3'h1;
        if (hit && col_hits_r != 2'h2) begin
          col_hits_r <= col_hits_r + 2'h1;
        end
      end
    end
  end

  // idle and scan end both start the next pass from a clean slate
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || state_r != kscan_pkg::ST_SCAN) begin
      row_hit_r <= 8'h00;
      key_idx_r <= 8'h00;
      found_r   <= 1'b0;
    end else if (tick) begin
      key_idx_r <= key_idx_r + 8'h01;
      if (hit) begin
        found_r <= 1'b1;
      end
      if (last_row && multi) begin
        row_hit_r <= row_hit_r | (row_db_r & row_mask);
      end
    end
  end

  // only new presses are queued; a held key is not queued again every pass
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || !enable) begin
      down_r <= 160'h0;
    end else if (step) begin
      down_r[key_idx_r] <= hit && !ghost_now;
    end
  end

  assign full    = (buf_cnt_r == 5'(`KS_BUF_DEPTH));
  assign push_ok = press && !full;
  // pop only a code the read returned, never one pushed during its wait state
  assign pop     = done && !PWRITE_I && PADDR_I == `KS_OFF_CODE && prdata_r[8];

  always_ff @(posedge SYS_CLK_I) begin
    if (push_ok) begin
      mem[wr_ptr_r] <= key_idx_r;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      wr_ptr_r  <= 4'h0;
      rd_ptr_r  <= 4'h0;
      buf_cnt_r <= 5'h00;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= wr_ptr_r + 4'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 4'h1;
      end
      buf_cnt_r <= buf_cnt_r + {4'h0, push_ok} - {4'h0, pop};
    end
  end

  // apb: one wait state, answer registered in the cycle after the access phase opens
  assign acc     = PSEL_I && PENABLE_I && !pready_r;
  assign done    = PSEL_I && PENABLE_I && pready_r;
  assign wr_ctrl = done && PWRITE_I && PADDR_I == `KS_OFF_CTRL;
  assign wr_stat = done && PWRITE_I && PADDR_I == `KS_OFF_STAT;

  always_comb begin
    rdata = 32'h0;
    err   = 1'b0;
    case (PADDR_I)
      `KS_OFF_CTRL: rdata = ctrl_r;
      `KS_OFF_STAT: rdata = {23'h0, buf_cnt_r, |down_r,
                             state_r != kscan_pkg::ST_IDLE, ovf_r, ghost_r};
      `KS_OFF_CODE: rdata = {23'h0, buf_cnt_r != 5'h00, mem[rd_ptr_r]};
      default:      err   = 1'b1;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc;
      prdata_r  <= acc ? rdata : 32'h0;
      pslverr_r <= acc && err;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ctrl_r <= `KS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= PWDATA_I & `KS_CTRL_MASK;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ghost_r <= 1'b0;
      ovf_r   <= 1'b0;
    end else begin
      ghost_r <= (step && ghost_now) ||
                 (ghost_r && !(wr_stat && PWDATA_I[`KS_ST_GHOST]));
      ovf_r   <= (press && full) ||
                 (ovf_r && !(wr_stat && PWDATA_I[`KS_ST_OVF]));
    end
  end

  assign PRDATA_O    = prdata_r;
  assign PREADY_O    = pready_r;
  assign PSLVERR_O   = pslverr_r;
  assign COL_O       = col_r;
  assign LPCLK_REQ_O = req_r;

  property p_req_off;
    @(posedge SYS_CLK_I) disable iff (RESET_I) !enable |=> !LPCLK_REQ_O;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request high while disabled");
  property p_wake;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (state_r == kscan_pkg::ST_IDLE && enable && row_db_r != row_db_d_r)
      |=> (state_r == kscan_pkg::ST_SCAN && LPCLK_REQ_O);
  endproperty
  a_wake: assert property (p_wake) else $error("row change did not wake scan");
  property p_idle_cols;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      state_r == kscan_pkg::ST_IDLE |=> COL_O == 20'hfffff;
  endproperty
  a_idle_cols: assert property (p_idle_cols) else $error("idle columns not high");
  property p_idle_clr;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      state_r == kscan_pkg::ST_IDLE |=> (row_hit_r == 8'h00 && key_idx_r == 8'h00);
  endproperty
  a_idle_clr: assert property (p_idle_clr) else $error("idle did not clear");
  property p_col_step;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (step && last_row && !last_col && enable)
      |=> (row_cnt_r == 3'h0 && col_cnt_r == $past(col_cnt_r) + 5'h01);
  endproperty
  a_col_step: assert property (p_col_step) else $error("column did not step");
  property p_end;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (step && last_row && last_col && enable) |=> state_r == kscan_pkg::ST_END;
  endproperty
  a_end: assert property (p_end) else $error("scan end not entered");
  property p_key_idx;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (step && enable) |=> key_idx_r == $past(key_idx_r) + 8'h01;
  endproperty
  a_key_idx: assert property (p_key_idx) else $error("key index did not advance");
  property p_to_idle;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (state_r == kscan_pkg::ST_END && !found_r)
      |=> (state_r == kscan_pkg::ST_IDLE && !LPCLK_REQ_O);
  endproperty
  a_to_idle: assert property (p_to_idle) else $error("empty pass not back to idle");
  property p_ghost;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (step && ghost_now) |=> (ghost_r && $stable(buf_cnt_r) || $past(pop));
  endproperty
  a_ghost: assert property (p_ghost) else $error("ghost not flagged");
  property p_ovf;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
      (press && full && !pop) |=> (ovf_r && buf_cnt_r == 5'(`KS_BUF_DEPTH));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
endmodule
`default_nettype wire

// ===== test/key_switch_matrix.sv
// behavioural key switch matrix seen by the scanner
`timescale 1ns/1ps
`default_nettype none
module key_switch_matrix (
  // column drives from the scanner
  input  wire logic [19:0]  col_i,
  // pressed keys, bit col*8+row
  input  wire logic [159:0] keys_i,
  // row lines, pulled low outside
  output logic      [7:0]   row_o
);
  // a closed switch joins its driven column to its row; open rows fall to the pull-down
  always_comb begin
    row_o = 8'h00;
    for (int c = 0; c < 20; c++) begin
      for (int r = 0; r < 8; r++) begin
        if (col_i[c] && keys_i[c*8+r]) begin
          row_o[r] = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         clk;
  logic         rst;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [7:0]   row;
  logic [19:0]  col;
  logic         lp_on;
  logic         lp_req;
  logic [159:0] keys;
  logic [31:0]  lfsr;
  logic [31:0]  rd;
  logic         err;
  int           fails;
  int           n_tests;
  int           exp_q[$];
  int           k;

  key_matrix_scanner i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ROW_I(row),
    .COL_O(col), .LPCLK_ON_I(lp_on), .LPCLK_REQ_O(lp_req));
  key_switch_matrix i_keys (.col_i(col), .keys_i(keys), .row_o(row));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one transfer, entered just after an edge; one idle cycle follows it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (i == 20) begin
      chk(32'h0, 32'h1, "apb timeout");
      finish_test();
    end
  endtask

  task automatic wait_req(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (lp_req === lvl) break;
      @(posedge clk);
    end
    chk({31'h0, lp_req}, {31'h0, lvl}, "clock request");
    if (i == lim) finish_test();
  endtask

  // host polls status until a pass has seen a key down
  task automatic poll_hit();
    for (int i = 0; i < 600; i++) begin
      apb(1'b0, 12'h004, 32'h0);
      if (rd[3] === 1'b1) break;
    end
    chk({31'h0, rd[3]}, 32'h1, "key seen");
    if (rd[3] !== 1'b1) finish_test();
  endtask

  // matrix set to 2 rows by 3 columns, so code = col*2+row
  task automatic tap(input int c, input int r);
    keys[c*8+r] <= 1'b1;
    lp_on <= lfsr[3];
    if (exp_q.size() < 16) exp_q.push_back(c * 2 + r);
    wait_req(1'b1, 400);
    poll_hit();
    keys[c*8+r] <= 1'b0;
    wait_req(1'b0, 6000);
    // columns go high one edge after the request falls
    @(posedge clk);
    chk({12'h0, col}, 32'h000f_ffff, "idle columns");
  endtask

  task automatic drain();
    while (exp_q.size() > 0) begin
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, {23'h0, 1'b1, 8'(exp_q.pop_front())}, "key code");
    end
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, rd[8]}, 32'h0, "empty valid");
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, lp_on} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    keys = '0;
    lfsr = 32'hf30d;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({12'h0, col}, 32'h000f_ffff, "reset columns");
    chk({31'h0, lp_req}, 32'h0, "reset request");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0014_0800, "ctrl reset");
    apb(1'b1, 12'h00c, lfsr);
    chk({31'h0, err}, 32'h1, "unmapped error");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 12'h000, k ? 32'h001f_0f00 : 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, k ? 32'h001f_0f00 : 32'h0000_0000, "ctrl limits");
    end
    $display("test registers done");
    apb(1'b1, 12'h000, 32'h0003_0201);
    // short glitch must not wake the scanner
    keys[0] <= 1'b1;
    repeat (20) @(posedge clk);
    keys[0] <= 1'b0;
    repeat (300) @(posedge clk);
    chk({31'h0, lp_req}, 32'h0, "glitch ignored");
    // disable while scanning drops the request at once
    keys[5*0+17] <= 1'b1;
    wait_req(1'b1, 400);
    apb(1'b1, 12'h000, 32'h0003_0200);
    // request falls one edge after the write lands
    @(posedge clk);
    chk({31'h0, lp_req}, 32'h0, "disabled request");
    keys[17] <= 1'b0;
    repeat (300) @(posedge clk);
    apb(1'b1, 12'h000, 32'h0003_0201);
    drain();
    $display("test wake and disable done");
    for (k = 0; k < 18; k++) begin
      lfsr = lfsr_next(lfsr);
      tap(int'(lfsr[7:0]) % 3, int'(lfsr[8]));
    end
    apb(1'b0, 12'h004, 32'h0);
    chk({27'h0, rd[8:4]}, 32'd16, "buffer count");
    chk({31'h0, rd[1]}, 32'h1, "overflow flag");
    drain();
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rd[1]}, 32'h0, "overflow clear");
    $display("test buffer overflow done");
    // keys at (0,0) (0,1) (1,0): third is a suspected ghost
    keys[1:0] <= 2'b11;
    keys[8] <= 1'b1;
    exp_q = '{0, 1};
    wait_req(1'b1, 400);
    poll_hit();
    // the ghost shows only once the second column is scanned
    repeat (1000) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "ghost flag");
    drain();
    keys <= '0;
    wait_req(1'b0, 6000);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "ghost clear");
    $display("test ghost done");
    finish_test();
  end
endmodule
`default_nettype wire
